// *** design/pc_shadow_pkg.sv ***
// Shared constants and types for the program counter and core shadow register block.
// Assumes one 25 MHz clock and a plain register port driven by the core's
// data-memory access logic.
package pc_shadow_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int ADDR_W      = 12;
  localparam int DATA_W      = 8;
  localparam int PC_W        = 15;
  localparam int PC_HIGH_W   = 7;
  localparam int STACK_PTR_W = 5;
  localparam int STACK_IDX_W = 4;
  localparam int STACK_DEPTH = 16;
  localparam int STATUS_W    = 3;
  localparam int BANK_W      = 5;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [ADDR_W-1:0] PC_LOW_OFFSET      = 12'h002;
  localparam logic [ADDR_W-1:0] PC_LATCH_OFFSET    = 12'h00a;
  localparam logic [ADDR_W-1:0] STATUS_SHAD_OFFSET = 12'hfe4;
  localparam logic [ADDR_W-1:0] WORKING_REG_SHADOW_OFFSET   = 12'hfe5;
  localparam logic [ADDR_W-1:0] BANK_SHAD_OFFSET   = 12'hfe6;
  localparam logic [ADDR_W-1:0] LATCH_SHAD_OFFSET  = 12'hfe7;
  localparam logic [ADDR_W-1:0] PTR0L_SHAD_OFFSET  = 12'hfe8;
  localparam logic [ADDR_W-1:0] PTR0H_SHAD_OFFSET  = 12'hfe9;
  localparam logic [ADDR_W-1:0] PTR1L_SHAD_OFFSET  = 12'hfea;
  localparam logic [ADDR_W-1:0] PTR1H_SHAD_OFFSET  = 12'hfeb;
  localparam logic [ADDR_W-1:0] STACK_PTR_OFFSET   = 12'hfed;
  localparam logic [ADDR_W-1:0] STACK_TOPL_OFFSET  = 12'hfee;
  localparam logic [ADDR_W-1:0] STACK_TOPH_OFFSET  = 12'hfef;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [PC_W-1:0]        PC_RESET        = 15'h0000;
  localparam logic [PC_HIGH_W-1:0]   LATCH_RESET     = 7'h00;
  localparam logic [STACK_PTR_W-1:0] STACK_PTR_EMPTY = 5'h1f;
  localparam logic [DATA_W-1:0]      SHADOW_RESET    = 8'h00;
  localparam logic [DATA_W-1:0]      READ_ZERO       = 8'h00;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic              wrEn;
    logic              rdEn;
  } reg_req_s;

  typedef struct packed {
    logic                  wrLow;
    logic                  wrHigh;
    logic [DATA_W-1:0]     lowData;
    logic [PC_HIGH_W-1:0]  highData;
  } stack_wr_s;

endpackage

// *** design/stack_word_mem.sv ***
// Sixteen-entry, fifteen-bit return stack storage with split byte lanes.
// Assumes the caller presents the read index of the next cycle, so that the
// registered read word always matches the current stack pointer.
module stack_word_mem
  import pc_shadow_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic [STACK_IDX_W-1:0] rdIndex,
  input  wire logic [STACK_IDX_W-1:0] wrIndex,
  input  wire stack_wr_s              wrReq,
  output logic      [PC_W-1:0]        rdWord
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [PC_W-1:0] words [STACK_DEPTH];
  logic [PC_W-1:0] mergedWord;

  // Lane merge of a write into the addressed entry
  always_comb begin
    mergedWord = words[wrIndex];
    if (wrReq.wrLow) begin
      mergedWord[DATA_W-1:0] = wrReq.lowData;
    end
    if (wrReq.wrHigh) begin
      mergedWord[PC_W-1:DATA_W] = wrReq.highData;
    end
  end

  // Write and registered read; a write to the entry being read passes through
  always_ff @(posedge sys_clk) begin
    if (wrReq.wrLow || wrReq.wrHigh) begin
      words[wrIndex] <= mergedWord;
    end
    if ((wrReq.wrLow || wrReq.wrHigh) && (wrIndex == rdIndex)) begin
      rdWord <= mergedWord;
    end else begin
      rdWord <= words[rdIndex];
    end
  end

endmodule

// *** design/program_counter_shadow_regs.sv ***
// Program counter with its high-byte latch, core shadow registers and the
// stack pointer with its top-of-stack window, reached over a plain register port.
// Assumes the core drives the port on sys_clk and pulses pcAdvance once per
// instruction; coreReset marks any reset other than power-on or brown-out.
//
// Function
// - The program counter holds fifteen bits covering all of program memory.
// - The low program counter byte is a software register that reads and writes.
// - Counter bits fourteen to eight are not software visible and load from the latch.
// - Every reset source clears the whole program counter to zero.
// - Shadow registers take any value at power-on and keep their contents on other resets.
// - Unused addresses and unused bits read as zero and ignore writes.
// - Writing the low counter byte loads bits fourteen to eight from the latch at once.
// - The five-bit stack pointer reads all ones when empty and after reset.
// - The top-of-stack pair reads and writes the entry picked by the stack pointer.
module program_counter_shadow_regs
  import pc_shadow_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   coreReset,
  input  wire logic                   pcAdvance,
  input  wire reg_req_s               busReq,
  output logic      [DATA_W-1:0]      rdData,
  output logic      [PC_W-1:0]        programCounter,
  output logic      [STACK_PTR_W-1:0] stackPointer
);

  // ************************************************************
  // Decode helpers
  // ************************************************************

  // True when a request addresses the given offset
  function automatic logic hits(input logic [ADDR_W-1:0] addr,
                                input logic [ADDR_W-1:0] offset);
    hits = (addr == offset);
  endfunction

  // Zero-extends a narrow field onto the data bus
  function automatic logic [DATA_W-1:0] widen7(input logic [PC_HIGH_W-1:0] value);
    widen7 = {1'b0, value};
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [PC_W-1:0]        pc;
    logic [PC_HIGH_W-1:0]   pcHighLatch;
    logic [STATUS_W-1:0]    statusShadow;
    logic [DATA_W-1:0]      workingShadow;
    logic [BANK_W-1:0]      bankShadow;
    logic [PC_HIGH_W-1:0]   latchShadow;
    logic [DATA_W-1:0]      pointer0LowShadow;
    logic [DATA_W-1:0]      pointer0HighShadow;
    logic [DATA_W-1:0]      pointer1LowShadow;
    logic [DATA_W-1:0]      pointer1HighShadow;
    logic [STACK_PTR_W-1:0] stackPtr;
    logic [DATA_W-1:0]      readData;
  } block_state_s;

  block_state_s state;
  block_state_s next_state;

  // Stack storage signals
  logic [PC_W-1:0] stackTopWord;
  stack_wr_s       stackWrite;

  // Request qualifiers
  logic wrReq;
  logic rdReq;

  assign wrReq = busReq.wrEn;
  assign rdReq = busReq.rdEn;

  // ************************************************************
  // Stack storage
  // ************************************************************

  // window on entry
  // The read index follows the next pointer so the registered word lines up
  // with the pointer in every cycle, including right after a pointer write.
  stack_word_mem stackMem (
    .sys_clk (sys_clk),
    .rdIndex (next_state.stackPtr[STACK_IDX_W-1:0]),
    .wrIndex (state.stackPtr[STACK_IDX_W-1:0]),
    .wrReq   (stackWrite),
    .rdWord  (stackTopWord)
  );

  // top-of-stack writes
  // Each half is written alone; the other lane keeps its stored bits.
  always_comb begin
    stackWrite.wrLow    = wrReq && hits(busReq.addr, STACK_TOPL_OFFSET);
    stackWrite.wrHigh   = wrReq && hits(busReq.addr, STACK_TOPH_OFFSET);
    stackWrite.lowData  = busReq.wrData;
    stackWrite.highData = busReq.wrData[PC_HIGH_W-1:0];
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    next_state = state;

    // Program counter stepping; a software write below takes priority
    if (pcAdvance) begin
      next_state.pc = state.pc + 15'h0001;
    end

    // ----- Program counter and latch writes -----
    if (wrReq) begin
      if (hits(busReq.addr, PC_LOW_OFFSET)) begin
        next_state.pc = {state.pcHighLatch, busReq.wrData};
      end
      if (hits(busReq.addr, PC_LATCH_OFFSET)) begin
        next_state.pcHighLatch = busReq.wrData[PC_HIGH_W-1:0];
      end
    end

    // ----- Shadow register writes -----
    // unused bits dropped
    // Only the implemented low bits of each shadow are stored.
    if (wrReq) begin
      if (hits(busReq.addr, STATUS_SHAD_OFFSET)) begin
        next_state.statusShadow = busReq.wrData[STATUS_W-1:0];
      end
      if (hits(busReq.addr, WORKING_REG_SHADOW_OFFSET)) begin
        next_state.workingShadow = busReq.wrData;
      end
      if (hits(busReq.addr, BANK_SHAD_OFFSET)) begin
        next_state.bankShadow = busReq.wrData[BANK_W-1:0];
      end
      if (hits(busReq.addr, LATCH_SHAD_OFFSET)) begin
        next_state.latchShadow = busReq.wrData[PC_HIGH_W-1:0];
      end
      if (hits(busReq.addr, PTR0L_SHAD_OFFSET)) begin
        next_state.pointer0LowShadow = busReq.wrData;
      end
      if (hits(busReq.addr, PTR0H_SHAD_OFFSET)) begin
        next_state.pointer0HighShadow = busReq.wrData;
      end
      if (hits(busReq.addr, PTR1L_SHAD_OFFSET)) begin
        next_state.pointer1LowShadow = busReq.wrData;
      end
      if (hits(busReq.addr, PTR1H_SHAD_OFFSET)) begin
        next_state.pointer1HighShadow = busReq.wrData;
      end
      // Moving the pointer repositions the top-of-stack window
      if (hits(busReq.addr, STACK_PTR_OFFSET)) begin
        next_state.stackPtr = busReq.wrData[STACK_PTR_W-1:0];
      end
    end

    // ----- Read data, valid in the cycle after the strobe only -----
    next_state.readData = READ_ZERO;
    if (rdReq) begin
      case (busReq.addr)
        PC_LOW_OFFSET:      next_state.readData = state.pc[DATA_W-1:0];
        PC_LATCH_OFFSET:    next_state.readData = widen7(state.pcHighLatch);
        STATUS_SHAD_OFFSET: next_state.readData = {5'h00, state.statusShadow};
        WORKING_REG_SHADOW_OFFSET:   next_state.readData = state.workingShadow;
        BANK_SHAD_OFFSET:   next_state.readData = {3'h0, state.bankShadow};
        LATCH_SHAD_OFFSET:  next_state.readData = widen7(state.latchShadow);
        PTR0L_SHAD_OFFSET:  next_state.readData = state.pointer0LowShadow;
        PTR0H_SHAD_OFFSET:  next_state.readData = state.pointer0HighShadow;
        PTR1L_SHAD_OFFSET:  next_state.readData = state.pointer1LowShadow;
        PTR1H_SHAD_OFFSET:  next_state.readData = state.pointer1HighShadow;
        STACK_PTR_OFFSET:   next_state.readData = {3'h0, state.stackPtr};
        STACK_TOPL_OFFSET:  next_state.readData = stackTopWord[DATA_W-1:0];
        STACK_TOPH_OFFSET:  next_state.readData = widen7(stackTopWord[PC_W-1:DATA_W]);
        default:            next_state.readData = READ_ZERO;
      endcase
    end

    // ----- Resets other than power-on -----
    // Shadows are left alone here so an interrupted context survives a
    // watchdog or software reset.
    if (coreReset) begin
      next_state.pc = PC_RESET;
      next_state.stackPtr = STACK_PTR_EMPTY;
      next_state.statusShadow = state.statusShadow;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************

  // power-on contents
  // Shadows power up with no defined meaning; zero is used so that
  // simulation stays free of unknowns, which is a legal unknown value.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state.pc                 <= PC_RESET;
      state.pcHighLatch        <= LATCH_RESET;
      state.statusShadow       <= SHADOW_RESET[STATUS_W-1:0];
      state.workingShadow      <= SHADOW_RESET;
      state.bankShadow         <= SHADOW_RESET[BANK_W-1:0];
      state.latchShadow        <= SHADOW_RESET[PC_HIGH_W-1:0];
      state.pointer0LowShadow  <= SHADOW_RESET;
      state.pointer0HighShadow <= SHADOW_RESET;
      state.pointer1LowShadow  <= SHADOW_RESET;
      state.pointer1HighShadow <= SHADOW_RESET;
      state.stackPtr           <= STACK_PTR_EMPTY;
      state.readData           <= READ_ZERO;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Outputs, all straight from the state register
  // ************************************************************
  assign rdData         = state.readData;
  assign programCounter = state.pc;
  assign stackPointer   = state.stackPtr;

endmodule

// *** sim/pc_shadow_properties.sv ***
// Checker for the program counter and shadow register block.
// Assumes it is bound to the top module and sees only that module's ports.
module pc_shadow_properties
  import pc_shadow_pkg::*;
(
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire logic                   coreReset,
  input wire logic                   pcAdvance,
  input wire reg_req_s               busReq,
  input wire logic [DATA_W-1:0]      rdData,
  input wire logic [PC_W-1:0]        programCounter,
  input wire logic [STACK_PTR_W-1:0] stackPointer
);
  timeunit 1ns;
  timeprecision 1ns;

  // ************************************************************
  // Decodes
  // ************************************************************
  // Writes that coreReset does not override
  logic wrPcLow;
  logic wrPtr;
  logic rdHit;
  assign wrPcLow = busReq.wrEn && busReq.addr == PC_LOW_OFFSET && !coreReset;
  assign wrPtr   = busReq.wrEn && busReq.addr == STACK_PTR_OFFSET && !coreReset;
  assign rdHit   = busReq.rdEn;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ************************************************************
  // Properties
  // ************************************************************
  a_read_idle_zero: assert property (!rdHit |=> rdData == READ_ZERO)
    else $error("read data not zero outside a read");
  a_pc_low_load: assert property (wrPcLow |=> programCounter[7:0] == $past(busReq.wrData))
    else $error("counter low byte not loaded by write");
  a_core_reset_clear: assert property (coreReset |=> programCounter == PC_RESET
    && stackPointer == STACK_PTR_EMPTY) else $error("core reset did not clear counter");
  a_pc_increment: assert property (pcAdvance && !coreReset && !wrPcLow
    |=> programCounter == $past(programCounter) + 15'h0001) else $error("counter step wrong");
  a_pc_hold: assert property (!pcAdvance && !coreReset && !wrPcLow
    |=> $stable(programCounter)) else $error("counter changed without cause");
  a_ptr_write: assert property (wrPtr |=> stackPointer == $past(busReq.wrData[4:0]))
    else $error("stack pointer write lost");
  a_ptr_read_back: assert property (rdHit && busReq.addr == STACK_PTR_OFFSET
    |=> rdData == {3'h0, $past(stackPointer)}) else $error("stack pointer read wrong");
  a_pc_low_read: assert property (rdHit && busReq.addr == PC_LOW_OFFSET
    |=> rdData == $past(programCounter[7:0])) else $error("counter low byte read wrong");
  a_top_high_msb: assert property (rdHit && busReq.addr == STACK_TOPH_OFFSET
    |=> !rdData[7]) else $error("stack top high bit seven not zero");
  a_gap_reads_zero: assert property (rdHit && busReq.addr == 12'hfec
    |=> rdData == READ_ZERO) else $error("unmapped address read not zero");
  a_status_unused: assert property (rdHit && busReq.addr == STATUS_SHAD_OFFSET
    |=> rdData[7:3] == 5'h00) else $error("status shadow unused bits not zero");

  // Main scenarios reached
  c_pc_load: cover property (wrPcLow);
  c_pc_step: cover property (pcAdvance && !coreReset);
  c_core_reset: cover property (coreReset);
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the program counter and shadow register block.
// Assumes the package, design and checker are compiled first; strobes last one clock.
module tb_top
  import pc_shadow_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                   sys_clk;
  logic                   rst;
  logic                   coreReset;
  logic                   pcAdvance;
  reg_req_s               busReq;
  logic [DATA_W-1:0]      rdData;
  logic [PC_W-1:0]        programCounter;
  logic [STACK_PTR_W-1:0] stackPointer;
  int                     fail_count;
  int                     n_checks;

  program_counter_shadow_regs i_dut (.sys_clk(sys_clk), .rst(rst), .coreReset(coreReset),
    .pcAdvance(pcAdvance), .busReq(busReq), .rdData(rdData),
    .programCounter(programCounter), .stackPointer(stackPointer));

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  // Strobe dropped after one edge, so calls never collide in one time step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    busReq <= '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
    @(posedge sys_clk);
    busReq.wrEn <= 1'b0;
    #1;
  endtask

  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge sys_clk);
    busReq <= '{addr: a, wrData: 8'h00, wrEn: 1'b0, rdEn: 1'b1};
    @(posedge sys_clk);
    busReq.rdEn <= 1'b0;
    #1;
    chk({8'h00, rdData}, {8'h00, exp});
  endtask

  task automatic step(input logic adv, input logic cr);
    @(posedge sys_clk);
    pcAdvance <= adv;
    coreReset <= cr;
    @(posedge sys_clk);
    pcAdvance <= 1'b0;
    coreReset <= 1'b0;
    #1;
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard: a run this long counts as a mismatch
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    finish_test();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [DATA_W-1:0] mask [8];
    mask = '{8'h07, 8'hff, 8'h1f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff};
    sys_clk = 1'b0;
    rst = 1'b1;
    coreReset = 1'b0;
    pcAdvance = 1'b0;
    busReq = '0;
    fail_count = 0;
    n_checks = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk({1'b0, programCounter}, 16'h0000);
    chk({11'h000, stackPointer}, 16'h001f);
    rc(STACK_PTR_OFFSET, 8'h1f);
    $display("test reset done");

    wr(PC_LATCH_OFFSET, 8'h12);
    wr(PC_LOW_OFFSET, 8'h34);
    chk({1'b0, programCounter}, 16'h1234);
    rc(PC_LOW_OFFSET, 8'h34);
    step(1'b1, 1'b0);
    chk({1'b0, programCounter}, 16'h1235);
    wr(PC_LATCH_OFFSET, 8'hff);
    rc(PC_LATCH_OFFSET, 8'h7f);
    wr(PC_LOW_OFFSET, 8'hff);
    chk({1'b0, programCounter}, 16'h7fff);
    step(1'b1, 1'b0);
    chk({1'b0, programCounter}, 16'h0000);
    $display("test counter done");

    for (int i = 0; i < 8; i++) wr(STATUS_SHAD_OFFSET + 12'(i), 8'hff ^ 8'(i));
    wr(PC_LOW_OFFSET, 8'h66);
    wr(STACK_PTR_OFFSET, 8'h03);
    step(1'b0, 1'b1);
    chk({1'b0, programCounter}, 16'h0000);
    chk({11'h000, stackPointer}, 16'h001f);
    for (int i = 0; i < 8; i++) rc(STATUS_SHAD_OFFSET + 12'(i), (8'hff ^ 8'(i)) & mask[i]);
    $display("test shadows done");

    for (int i = 0; i < 16; i++) begin
      wr(STACK_PTR_OFFSET, 8'(i));
      wr(STACK_TOPL_OFFSET, 8'(i * 5));
      wr(STACK_TOPH_OFFSET, 8'hf0 | 8'(i));
    end
    for (int i = 15; i >= 0; i--) begin
      wr(STACK_PTR_OFFSET, 8'(i));
      rc(STACK_TOPL_OFFSET, 8'(i * 5));
      rc(STACK_TOPH_OFFSET, 8'h70 | 8'(i));
    end
    wr(STACK_PTR_OFFSET, 8'hff);
    rc(STACK_PTR_OFFSET, 8'h1f);
    rc(STACK_TOPL_OFFSET, 8'(75));
    $display("test stack done");

    wr(12'hfec, 8'hff);
    rc(12'hfec, 8'h00);
    rc(12'h000, 8'h00);
    rc(PTR1H_SHAD_OFFSET, 8'hf8);
    $display("test unmapped done");

    // Same-cycle contests: a write beats a step, a core reset beats a write
    wr(PC_LATCH_OFFSET, 8'h05);
    @(posedge sys_clk);
    busReq <= '{addr: PC_LOW_OFFSET, wrData: 8'h80, wrEn: 1'b1, rdEn: 1'b0};
    pcAdvance <= 1'b1;
    @(posedge sys_clk);
    busReq.wrEn <= 1'b0;
    pcAdvance <= 1'b0;
    #1;
    chk({1'b0, programCounter}, 16'h0580);
    @(posedge sys_clk);
    busReq <= '{addr: STACK_PTR_OFFSET, wrData: 8'h04, wrEn: 1'b1, rdEn: 1'b0};
    coreReset <= 1'b1;
    @(posedge sys_clk);
    busReq.wrEn <= 1'b0;
    coreReset <= 1'b0;
    #1;
    chk({11'h000, stackPointer}, 16'h001f);
    chk({1'b0, programCounter}, 16'h0000);
    rc(PC_LATCH_OFFSET, 8'h05);
    $display("test priority done");

    // Power-on reset in mid-run clears the counter and empties the stack
    step(1'b1, 1'b0);
    chk({1'b0, programCounter}, 16'h0001);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk({1'b0, programCounter}, 16'h0000);
    chk({11'h000, stackPointer}, 16'h001f);
    rc(PC_LOW_OFFSET, 8'h00);
    rc(STACK_PTR_OFFSET, 8'h1f);
    $display("test second reset done");
    finish_test();
  end
endmodule

bind program_counter_shadow_regs pc_shadow_properties i_props (.sys_clk(sys_clk), .rst(rst),
  .coreReset(coreReset), .pcAdvance(pcAdvance), .busReq(busReq), .rdData(rdData),
  .programCounter(programCounter), .stackPointer(stackPointer));
